// File: logic/sld_device.sv
/*
 Driver device end: shift register, storage register, blanked sink outputs.
 Assumes all link pins are asynchronous to mclk_i; each passes two flops
 before any register reads it, and edges of the link clocks are found on
 the synced copies. Only the serial out gate reads the raw clear pin.
*/
`timescale 1ns/10ps
`include "sld_defs.svh"
module sld_device
   import sld_pkg::*;
#(
   parameter int WIDTH = `SLD_WIDTH
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   sld_link_if.device            link,
   output logic [WIDTH-1:0]      sink_on_o,
   output logic [WIDTH-1:0]      storage_o
);
   initial begin
      if (WIDTH < 2) $error("sld_device: WIDTH must be at least 2");
   end

   logic [1:0]       sck_sync;
   logic [1:0]       lck_sync;
   logic [1:0]       clr_sync;
   logic [1:0]       blank_sync;
   logic [1:0]       din_sync;
   logic             sck_prev;
   logic             lck_prev;
   logic [WIDTH-1:0] shift_reg;
   logic [WIDTH-1:0] next_shift_reg;
   logic [WIDTH-1:0] storage;
   logic [WIDTH-1:0] out_buffer;
   logic             serial_out;
   logic             clear_now;
   logic             blank_now;
   logic             sck_rise;
   logic             sck_fall;
   logic             lck_rise;

   // Rising edge of a synced pin
   function automatic logic edge_up(input logic now_v, input logic was_v);
      return now_v && !was_v;
   endfunction

   // Falling edge of a synced pin
   function automatic logic edge_down(input logic now_v, input logic was_v);
      return !now_v && was_v;
   endfunction

   // Data and both clocks pass equal two-flop chains,
   // so each data bit stays aligned with its clock edge
   // Shift clock pin synchroniser
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sck_sync <= 2'h0;
      end else begin
         sck_sync <= {sck_sync[0], link.shift_clock};
      end
   end

   // Latch clock pin synchroniser
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         lck_sync <= 2'h0;
      end else begin
         lck_sync <= {lck_sync[0], link.latch_clock};
      end
   end

   // Clear pin synchroniser, clearing during reset
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         clr_sync <= 2'h0;
      end else begin
         clr_sync <= {clr_sync[0], link.register_clear_n};
      end
   end

   // Blanking pin synchroniser, blanked during reset
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         blank_sync <= 2'h3;
      end else begin
         blank_sync <= {blank_sync[0], link.output_blank};
      end
   end

   // Serial data pin synchroniser
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         din_sync <= 2'h0;
      end else begin
         din_sync <= {din_sync[0], link.chain_data_in};
      end
   end

   // Shift clock history for edge finding
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sck_prev <= 1'h0;
      end else begin
         sck_prev <= sck_sync[1];
      end
   end

   // Latch clock history for edge finding
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         lck_prev <= 1'h0;
      end else begin
         lck_prev <= lck_sync[1];
      end
   end

   // registers clear on the synced pin only
   // the raw pin is never read by a register
   // Edges lag the pins by about two cycles
   assign clear_now = !clr_sync[1];
   assign blank_now = blank_sync[1];
   assign sck_rise  = edge_up(sck_sync[1], sck_prev);
   assign sck_fall  = edge_down(sck_sync[1], sck_prev);
   assign lck_rise  = edge_up(lck_sync[1], lck_prev);

   // stage 0 in, toward stage 7
   always_comb begin
      next_shift_reg = {shift_reg[WIDTH-2:0], din_sync[1]};
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i || clear_now) begin
         shift_reg <= '0;
      end else if (sck_rise) begin
         shift_reg <= next_shift_reg;
      end
   end

   // clear zeroes storage
   // Latch copy ignores the shift clock
   always_ff @(posedge mclk_i) begin
      if (rst_i || clear_now) begin
         storage <= '0;
      end else if (lck_rise) begin
         storage <= shift_reg;
      end
   end

   // serial out on falling edge
   // Stage 7 as of the last rising edge;
   // the next stage gets half a period of hold
   always_ff @(posedge mclk_i) begin
      if (rst_i || clear_now) begin
         serial_out <= 1'b0;
      end else if (sck_fall) begin
         serial_out <= shift_reg[WIDTH-1];
      end
   end

   // raw clear pin forces serial out low
   // at once, without waiting for the synchronisers
   assign link.chain_data_out = serial_out && link.register_clear_n;

   // buffer takes storage only while clear high
   always_comb begin
      if (clear_now) begin
         out_buffer = '0;
      end else begin
         out_buffer = storage;
      end
   end

   // a one sinks, a zero is off
   // Registered so the sink outputs never glitch
   always_ff @(posedge mclk_i) begin
      if (rst_i || blank_now) begin
         sink_on_o <= '0;
      end else begin
         sink_on_o <= out_buffer;
      end
   end

   // Stored word, for observation only
   assign storage_o = storage;
endmodule

// File: logic/sld_defs.svh
/*
 Constants for the serial latched driver link: widths and timing counts.
 Assumes a 20 MHz system clock on both ends.
*/
`ifndef SLD_DEFS_SVH
`define SLD_DEFS_SVH

`define SLD_WIDTH          8
`define SLD_CHAIN_LEN      2
`define SLD_CLK_NS         50
`define SLD_SHIFT_MAX_MHZ  10
`define SLD_SHIFT_MIN_NS   (1000 / `SLD_SHIFT_MAX_MHZ)
`define SLD_HALF_NS        200
`define SLD_HALF_CYC       ((`SLD_HALF_NS + `SLD_CLK_NS - 1) / `SLD_CLK_NS)

`endif

// File: logic/sld_pkg.sv
/*
 Types shared by both ends of the serial latched driver link.
 Assumes the constants header is compiled alongside.
*/
package sld_pkg;
   typedef enum logic [2:0] {
      SLD_IDLE  = 3'b000,
      SLD_LOW   = 3'b001,
      SLD_HIGH  = 3'b011,
      SLD_LATCH = 3'b010,
      SLD_LREL  = 3'b110
   } sld_host_state_type;
endpackage

// File: logic/sld_link_if.sv
/*
 Link between the controller and the driver device.
 Assumes the bench joins both modports; all signals are plain wires.
*/
`timescale 1ns/10ps
interface sld_link_if;
   logic shift_clock;
   logic latch_clock;
   logic register_clear_n;
   logic output_blank;
   logic chain_data_in;
   logic chain_data_out;

   modport device (
      input  shift_clock,
      input  latch_clock,
      input  register_clear_n,
      input  output_blank,
      input  chain_data_in,
      output chain_data_out
   );
   modport host (
      output shift_clock,
      output latch_clock,
      output register_clear_n,
      output output_blank,
      output chain_data_in,
      input  chain_data_out
   );
endinterface

// File: logic/sld_host.sv
/*
 Controller end: shifts a word out, one pulse per bit, then latches.
 Assumes a start pulse from user logic on mclk_i; shift clock is divided
 from mclk_i, so the returning serial data is sampled through two flops.
*/
`timescale 1ns/10ps
`include "sld_defs.svh"
module sld_host
   import sld_pkg::*;
#(
   parameter int BITS     = `SLD_WIDTH * `SLD_CHAIN_LEN,
   parameter int HALF_CYC = `SLD_HALF_CYC
) (
   input  wire logic            mclk_i,
   input  wire logic            rst_i,
   input  wire logic            start_i,
   input  wire logic [BITS-1:0] data_i,
   input  wire logic            clear_req_i,
   input  wire logic            blank_i,
   output logic                 busy_o,
   output logic                 done_o,
   output logic [BITS-1:0]      echo_o,
   sld_link_if.host             link
);
   initial begin
      if (BITS < 2 || BITS > 255) $error("sld_host: BITS out of range");
      // Far end needs three cycles per pin level
      if (HALF_CYC < 3 || HALF_CYC > 256)
         $error("sld_host: HALF_CYC out of range");
      if (2 * HALF_CYC * `SLD_CLK_NS < `SLD_SHIFT_MIN_NS)
         $error("sld_host: shift clock too fast");
   end

   sld_host_state_type state;
   logic [7:0]         half_cnt;
   logic [7:0]         bit_cnt;
   logic [BITS-1:0]    shreg;
   logic [1:0]         dout_sync;
   logic               clr_n;
   logic               tick;

   assign tick = (half_cnt == 8'(HALF_CYC - 1));

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         dout_sync <= 2'h0;
      end else begin
         dout_sync <= {dout_sync[0], link.chain_data_out};
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         clr_n <= 1'b0;
      end else begin
         clr_n <= !clear_req_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i || state == SLD_IDLE || tick) begin
         half_cnt <= 8'h00;
      end else begin
         half_cnt <= half_cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state   <= SLD_IDLE;
         bit_cnt <= 8'h00;
         shreg   <= '0;
         done_o  <= 1'b0;
         echo_o  <= '0;
      end else begin
         done_o <= 1'b0;
         unique case (state)
            SLD_IDLE: begin
               if (start_i && clr_n) begin
                  shreg   <= data_i;
                  bit_cnt <= 8'h00;
                  state   <= SLD_LOW;
               end
            end
            SLD_LOW: if (tick) state <= SLD_HIGH;
            SLD_HIGH: begin
               if (tick) begin
                  shreg   <= {shreg[BITS-2:0], dout_sync[1]};
                  bit_cnt <= bit_cnt + 8'h01;
                  if (bit_cnt == 8'(BITS - 1)) state <= SLD_LATCH;
                  else state <= SLD_LOW;
               end
            end
            SLD_LATCH: if (tick) state <= SLD_LREL;
            SLD_LREL: begin
               if (tick) begin
                  echo_o <= shreg;
                  done_o <= 1'b1;
                  state  <= SLD_IDLE;
               end
            end
            default: state <= SLD_IDLE;
         endcase
      end
   end

   assign link.chain_data_in    = shreg[BITS-1];
   assign link.shift_clock      = (state == SLD_HIGH);
   assign link.latch_clock      = (state == SLD_LATCH);
   assign link.register_clear_n = clr_n;
   assign link.output_blank     = blank_i || rst_i;
   assign busy_o                = (state != SLD_IDLE);
endmodule

// File: testbench/sld_link_assertions.sv
/* Checker for the link between host and device ends.
 Assumes the link wires and device outputs, HALF_CYC of 4. */
`timescale 1ns/10ps
module sld_link_assertions (
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   input  wire logic       shift_clock,
   input  wire logic       latch_clock,
   input  wire logic       register_clear_n,
   input  wire logic       output_blank,
   input  wire logic       chain_data_in,
   input  wire logic       chain_data_out,
   input  wire logic [7:0] sink_on_o,
   input  wire logic [7:0] storage_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   a_clear_out_low: assert property (!register_clear_n |-> !chain_data_out)
      else $error("serial out high in clear");
   a_clear_store: assert property ((!register_clear_n)[*5] |-> !storage_o)
      else $error("storage kept in clear");
   a_blank_off: assert property (output_blank[*5] |-> !sink_on_o)
      else $error("sink on while blanked");
   a_sink_follow: assert property ((register_clear_n && !output_blank
      && $stable(storage_o))[*6] |-> sink_on_o == storage_o)
      else $error("sink differs from storage");
   a_latch_only: assert property ((register_clear_n && !latch_clock)[*8]
      |-> $stable(storage_o))
      else $error("storage moved without latch");
   a_out_on_fall: assert property (register_clear_n && $past(register_clear_n)
      && $changed(chain_data_out) |-> !shift_clock)
      else $error("serial out moved on high clock");
   a_shift_width: assert property ($rose(shift_clock)
      |-> shift_clock[*4] ##1 !shift_clock)
      else $error("shift clock width");
   a_latch_after: assert property ($rose(latch_clock)
      |-> (latch_clock && !shift_clock)[*4] ##1 !latch_clock)
      else $error("latch pulse bad");
   a_data_steady: assert property (shift_clock |-> $stable(chain_data_in))
      else $error("data moved on high clock");
   cover property ($rose(latch_clock));
   cover property (output_blank ##1 !output_blank);
   cover property ($fell(register_clear_n));
endmodule

// File: testbench/testbench.sv
/* Bench: host end drives one device end over the link.
 Assumes 20 MHz mclk_i, host BITS of 8, one device. */
`timescale 1ns/10ps
module testbench;
   logic       mclk_i = 1'h0;
   logic       rst_i = 1'h1;
   logic       start_i = 1'h0;
   logic [7:0] data_i = 8'h00;
   logic       clear_req_i = 1'h0;
   logic       blank_i = 1'h0;
   logic       busy_o;
   logic       done_o;
   logic [7:0] echo_o;
   logic [7:0] sink_on_o;
   logic [7:0] storage_o;
   logic [7:0] prev = 8'h00;
   int         error_cnt = 0;
   int         checks_done = 0;
   sld_link_if link ();
   always #25 mclk_i = ~mclk_i;
   sld_host #(.BITS(8), .HALF_CYC(4)) sld_host_inst (.mclk_i(mclk_i),
      .rst_i(rst_i), .start_i(start_i), .data_i(data_i),
      .clear_req_i(clear_req_i), .blank_i(blank_i), .busy_o(busy_o),
      .done_o(done_o), .echo_o(echo_o), .link(link));
   sld_device sld_device_inst (.mclk_i(mclk_i), .rst_i(rst_i), .link(link),
      .sink_on_o(sink_on_o), .storage_o(storage_o));
   sld_link_assertions sld_link_assertions_inst (.mclk_i(mclk_i),
      .rst_i(rst_i), .shift_clock(link.shift_clock),
      .latch_clock(link.latch_clock), .chain_data_in(link.chain_data_in),
      .register_clear_n(link.register_clear_n),
      .output_blank(link.output_blank), .chain_data_out(link.chain_data_out),
      .sink_on_o(sink_on_o), .storage_o(storage_o));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function logic [7:0] exp_sink(input logic [7:0] d, input logic b);
      return b ? 8'h00 : d;
   endfunction
   task frame(input logic [7:0] d);
      logic seen;
      seen = 1'h0;
      @(negedge mclk_i);
      data_i = d;
      start_i = 1'h1;
      @(negedge mclk_i);
      start_i = 1'h0;
      chk({7'h00, busy_o}, 8'h01);
      repeat (300) begin
         @(negedge mclk_i);
         if (done_o === 1'h1) seen = 1'h1;
         if (seen) break;
      end
      chk({7'h00, seen}, 8'h01);
      chk({7'h00, busy_o}, 8'h00);
      repeat (8) @(negedge mclk_i);
      chk(storage_o, d);
      chk(echo_o, prev);
      chk(sink_on_o, exp_sink(d, blank_i));
      prev = d;
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h4d41));
      repeat (12) @(negedge mclk_i);
      rst_i = 1'h0;
      repeat (6) @(negedge mclk_i);
      chk(sink_on_o, 8'h00);
      frame(8'h80);
      frame(8'h01);
      frame(8'hff);
      frame(8'h00);
      for (int i = 0; i < 6; i++) frame(8'($urandom));
      $display("frames done");
      blank_i = 1'h1;
      frame(8'h5a);
      for (int i = 0; i < 4; i++) begin
         blank_i = ~blank_i;
         repeat (8) @(negedge mclk_i);
         chk(sink_on_o, exp_sink(8'h5a, blank_i));
      end
      $display("blanking done");
      clear_req_i = 1'h1;
      repeat (8) @(negedge mclk_i);
      chk(storage_o, 8'h00);
      chk(sink_on_o, 8'h00);
      chk({7'h00, link.chain_data_out}, 8'h00);
      clear_req_i = 1'h0;
      repeat (4) @(negedge mclk_i);
      prev = 8'h00;
      frame(8'hc3);
      $display("clear done");
      end_of_test();
   end
   initial begin
      #200000;
      error_cnt++;
      end_of_test();
   end
endmodule
